// ### aop_defines.svh
// Constants for the converter output and power-down control block
`ifndef AOP_DEFINES_SVH
`define AOP_DEFINES_SVH
`define AOP_WIDTH 12
`define AOP_MSB 11
`define AOP_LATENCY 6
`define AOP_LAST_STAGE 5
`define AOP_FIFO_DEPTH 8
`define AOP_OFFSET_FLIP 12'h800
`define AOP_SLEEP_DATA 12'h000
`define AOP_OEN_FLOAT 12'hFFF
`define AOP_OEN_DRIVE 12'h000
`define AOP_CLK_PERIOD_NS 10
`endif

// ### aop_pkg.sv
// Types shared by the converter output and power-down control block
`include "aop_defines.svh"
package aop_pkg;
	typedef struct packed
	{
		logic valid;
		logic [`AOP_MSB:0] code;
	} aop_word_t;
	typedef enum logic [2:0]
	{
		AOP_ACTIVE = 3'b001,
		AOP_SLEEP = 3'b010,
		AOP_REFILL = 3'b100
	} aop_state_t;
endpackage : aop_pkg

// ### aop_ctl.sv
// Converter pipeline, output FIFO, three-state output pins and power-down control
// Summary of operation
// (RULE_01) Enable high floats all data pins
// (RULE_02) Enable low drives all data pins
// (RULE_03) Conversion continues whatever the enable level
// (RULE_04) Sleep request holds low-power unusable state
// (RULE_05) Data pins undefined while asleep; invalid
// (RULE_06) Sleep entry discards every in-flight sample
// (RULE_07) Host waits recovery time after wake
// (RULE_08) Offset-binary word valid with both inputs low
// (RULE_09) Host latches word on falling clock edge
// (RULE_10) Enable not used for bus sharing
// (RULE_11) Host supplies continuous sampling clock
// (RULE_12) One word per clock, fixed latency; stale FIFO words add latency after the pins float, until sleep or reset
`timescale 1ns/10ps
`default_nettype none
`include "aop_defines.svh"

module aop_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic flush,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != '0);
	assign out_data = mem[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst || flush)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop)
			begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : aop_fifo

module aop_ctl (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RESET,
	// Control pins
	input wire logic OE_N,
	input wire logic SLEEP_REQUEST,
	// Raw two's complement code from the quantizer core
	input wire logic [`AOP_MSB:0] CORE_CODE,
	// Data pins
	output logic [`AOP_MSB:0] DATA_OUT,
	output logic [`AOP_MSB:0] DATA_OEN,
	// Status
	output logic WORD_VALID,
	output logic OVERRUN,
	output logic CONVERTING
);
	aop_pkg::aop_word_t pipe_q [`AOP_LATENCY];
	aop_pkg::aop_state_t state_q;
	aop_pkg::aop_state_t state_d;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [`AOP_MSB:0] fifo_out_data;
	logic [`AOP_MSB:0] data_out_q;
	logic [`AOP_MSB:0] data_oen_q;
	logic word_valid_q;
	logic overrun_q;
	logic converting_q;

	// Power state: sleep, then refill until the pipeline holds fresh samples
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			aop_pkg::AOP_ACTIVE:
			begin
				if (SLEEP_REQUEST)
				begin
					state_d = aop_pkg::AOP_SLEEP; // RULE_04
				end
			end
			aop_pkg::AOP_SLEEP:
			begin
				if (!SLEEP_REQUEST)
				begin
					state_d = aop_pkg::AOP_REFILL;
				end
			end
			aop_pkg::AOP_REFILL:
			begin
				if (SLEEP_REQUEST)
				begin
					state_d = aop_pkg::AOP_SLEEP;
				end
				else if (pipe_q[`AOP_LAST_STAGE].valid)
				begin
					state_d = aop_pkg::AOP_ACTIVE;
				end
			end
			default:
			begin
				state_d = aop_pkg::AOP_SLEEP;
			end
		endcase
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RESET)
		begin
			state_q <= aop_pkg::AOP_REFILL;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// Pipeline ignores the output enable entirely; a sample is taken every clock outside reset and sleep
	always_ff @(posedge REF_CLK)
	begin
		if (RESET || SLEEP_REQUEST)
		begin
			pipe_q[0] <= '0; // RULE_04
		end
		else
		begin
			pipe_q[0].valid <= 1'b1; // RULE_03
			pipe_q[0].code <= CORE_CODE ^ `AOP_OFFSET_FLIP; // RULE_08
		end
	end

	// Sleep wipes every stage, so corrupted samples never reach the pins
	generate
		for (genvar i = 1; i < `AOP_LATENCY; i++)
		begin : g_stage
			always_ff @(posedge REF_CLK)
			begin
				if (RESET || SLEEP_REQUEST)
				begin
					pipe_q[i] <= '0; // RULE_06
				end
				else
				begin
					pipe_q[i] <= pipe_q[i-1]; // RULE_12
				end
			end
		end
	endgenerate

	// Draining stalls while the pins float, so the FIFO fills and then drops
	// the newest words; stale words are shown first once the pins drive again
	assign fifo_out_ready = !OE_N && !SLEEP_REQUEST;

	aop_fifo #(
		.WIDTH(`AOP_WIDTH),
		.DEPTH(`AOP_FIFO_DEPTH)
	) u_fifo (
		.clk(REF_CLK),
		.rst(RESET),
		.flush(SLEEP_REQUEST), // RULE_06
		.in_valid(pipe_q[`AOP_LAST_STAGE].valid),
		.in_ready(fifo_in_ready),
		.in_data(pipe_q[`AOP_LAST_STAGE].code),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	always_ff @(posedge REF_CLK)
	begin
		if (RESET)
		begin
			data_out_q <= `AOP_SLEEP_DATA;
			word_valid_q <= 1'b0;
		end
		else if (SLEEP_REQUEST)
		begin
			data_out_q <= `AOP_SLEEP_DATA; // RULE_05
			word_valid_q <= 1'b0; // RULE_05
		end
		else if (fifo_out_valid && fifo_out_ready)
		begin
			data_out_q <= fifo_out_data; // RULE_12
			word_valid_q <= 1'b1; // RULE_08
		end
		else
		begin
			word_valid_q <= 1'b0;
		end
	end

	// Pin drivers follow the enable one clock later
	always_ff @(posedge REF_CLK)
	begin
		if (RESET)
		begin
			data_oen_q <= `AOP_OEN_FLOAT;
		end
		else if (OE_N)
		begin
			data_oen_q <= `AOP_OEN_FLOAT; // RULE_01
		end
		else
		begin
			data_oen_q <= `AOP_OEN_DRIVE; // RULE_02
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RESET)
		begin
			overrun_q <= 1'b0;
		end
		else
		begin
			overrun_q <= pipe_q[`AOP_LAST_STAGE].valid && !fifo_in_ready && !SLEEP_REQUEST;
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RESET)
		begin
			converting_q <= 1'b0;
		end
		else
		begin
			converting_q <= (state_d == aop_pkg::AOP_ACTIVE);
		end
	end

	assign DATA_OUT = data_out_q;
	assign DATA_OEN = data_oen_q;
	assign WORD_VALID = word_valid_q;
	assign OVERRUN = overrun_q;
	assign CONVERTING = converting_q;

	a_oe_float_pins: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_01
		OE_N |=> (DATA_OEN == `AOP_OEN_FLOAT))
	else $error("Pins not floated after enable went high");

	a_oe_drive_pins: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_02
		!OE_N |=> (DATA_OEN == `AOP_OEN_DRIVE))
	else $error("Pins not driven after enable went low");

	a_convert_during_float: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_03
		(OE_N && !SLEEP_REQUEST)[*3] |-> pipe_q[0].valid && pipe_q[1].valid)
	else $error("Conversion stopped while pins float");

	a_sleep_holds_off: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_04
		SLEEP_REQUEST[*2] |-> state_q == aop_pkg::AOP_SLEEP && !CONVERTING)
	else $error("Not in sleep state while request held");

	a_sleep_word_invalid: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_05
		SLEEP_REQUEST |=> !WORD_VALID && DATA_OUT == `AOP_SLEEP_DATA)
	else $error("Word marked valid during sleep");

	a_sleep_flushes_all: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_06
		SLEEP_REQUEST ##1 !SLEEP_REQUEST |-> !fifo_out_valid
		##1 !pipe_q[`AOP_LAST_STAGE].valid)
	else $error("In-flight sample survived sleep");

	a_valid_needs_enables: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_08
		WORD_VALID |-> $past(!OE_N) && $past(!SLEEP_REQUEST))
	else $error("Valid word without both inputs low");

	a_fixed_latency: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_12
		(!SLEEP_REQUEST)[*6] |=> pipe_q[`AOP_LAST_STAGE].valid
		&& pipe_q[`AOP_LAST_STAGE].code == ($past(CORE_CODE, 6) ^ `AOP_OFFSET_FLIP))
	else $error("Pipeline latency or coding wrong");

	a_wake_refill_time: assert property (@(posedge REF_CLK) disable iff (RESET) // RULE_12
		$fell(SLEEP_REQUEST) ##1 (!SLEEP_REQUEST)[*6] |-> !CONVERTING ##1 CONVERTING)
	else $error("Refill after wake not six clocks");
endmodule : aop_ctl
`default_nettype wire

// ### aop_capture.sv
// Capture logic model that latches converter words on the falling clock edge
`timescale 1ns/10ps
`default_nettype none
module aop_capture (
	// Clock
	input wire logic clk,
	// Converter pins on a dedicated path
	input wire logic [11:0] data,
	input wire logic [11:0] oen,
	input wire logic valid,
	input wire logic ready,
	// Captured result
	output logic [11:0] word
);
	// Refill words are dropped too, so the host waits out recovery
	always @(negedge clk)
		if (valid && ready && oen === 12'h000)
			word <= data;
endmodule : aop_capture
`default_nettype wire

// ### aop_ctl_tb.sv
// Testbench for the converter output and power-down control block
`timescale 1ns/10ps
`default_nettype none
module aop_ctl_tb;
	logic REF_CLK = 1'b0;
	logic RESET = 1'b1;
	logic OE_N = 1'b0;
	logic SLEEP_REQUEST = 1'b0;
	logic [11:0] core_code = 12'h000;
	logic [11:0] data_out;
	logic [11:0] data_oen;
	logic [11:0] cap_word;
	logic word_valid;
	logic overrun;
	logic converting;
	int n_fail = 0;
	int check_count = 0;
	int n;
	always #5 REF_CLK = ~REF_CLK;
	aop_ctl u_dut (.REF_CLK(REF_CLK), .RESET(RESET), .OE_N(OE_N),
		.SLEEP_REQUEST(SLEEP_REQUEST), .CORE_CODE(core_code), .DATA_OUT(data_out),
		.DATA_OEN(data_oen), .WORD_VALID(word_valid), .OVERRUN(overrun),
		.CONVERTING(converting));
	aop_capture u_cap (.clk(REF_CLK), .data(data_out), .oen(data_oen),
		.valid(word_valid), .ready(converting), .word(cap_word));
	task tick;
		@(posedge REF_CLK);
		#1;
		// A ramp makes every word traceable to its sample
		core_code = core_code + 12'h001;
	endtask : tick
	task check(input logic [11:0] got, input logic [11:0] exp);
		check_count++;
		if (got !== exp)
		begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			n_fail++;
		end
	endtask : check
	task summarize;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	task t_reset;
		n = 0;
		do
		begin
			tick;
			n++;
		end
		while (word_valid !== 1'b1 && n < 20);
		check(12'(n), 12'h008);
	endtask : t_reset
	task t_stream;
		repeat (8)
		begin
			check({11'h000, word_valid}, 12'h001);
			check(data_out, (core_code - 12'h008) ^ 12'h800);
			tick;
		end
		check(cap_word, (core_code - 12'h009) ^ 12'h800);
	endtask : t_stream
	task t_oe;
		OE_N = 1'b1;
		tick;
		check(data_oen, 12'hFFF);
		n = 0;
		repeat (20)
		begin
			tick;
			n += overrun;
			check({11'h000, converting}, 12'h001);
		end
		check({11'h000, n > 8}, 12'h001);
		OE_N = 1'b0;
		tick;
		check(data_oen, 12'h000);
		check({11'h000, word_valid}, 12'h001);
	endtask : t_oe
	task t_sleep;
		SLEEP_REQUEST = 1'b1;
		tick;
		check({11'h000, word_valid}, 12'h000);
		check(data_out, 12'h000);
		tick;
		check({11'h000, converting}, 12'h000);
		repeat (3) tick;
		SLEEP_REQUEST = 1'b0;
		repeat (6)
		begin
			tick;
			check({11'h000, word_valid}, 12'h000);
		end
		tick;
		check({11'h000, converting}, 12'h001);
		tick;
		check({11'h000, word_valid}, 12'h001);
	endtask : t_sleep
	initial
	begin
		repeat (8) tick;
		RESET = 1'b0;
		t_reset;
		t_stream;
		t_oe;
		t_sleep;
		t_stream;
		summarize;
	end
	initial
	begin
		#20000;
		n_fail++;
		summarize;
	end
endmodule : aop_ctl_tb
`default_nettype wire
